/* logic/tmr_core.sv */
// 16-bit timer and event counter with AXI4-Lite register access
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// How it works
// - Counter increments per selected event; wrap to zero sets request flag.
// - Mode bit 1 gates the request flag onto the interrupt.
// - Mode bit 7 stops counting when zero, runs when one.
// - Mode bits 6:4 pick clock divided by 256 down to 2.
// - Mode bit 3 picks prescaled clock or external source; resistiveOscEnable picks pin or oscillator output.
// - Edge bit 0 picks falling or rising edge counting.
// - Edge bit 1 enables width measure; bit 0 picks high or low pulse.
// - Reading high byte also copies counter low byte into low latch.
// - Writing high byte loads whole counter; low write alone does not.
// - Preloaded counter overflows after 65536 minus preload events.
// - Request flag is read/write; hardware sets, software writes zero.
// - Width mode holds count at end edge; flag clear rearms.
// - High pulse: rise starts, fall stops; low pulse the reverse.
module tmr_core (
  input wire logic clk, // 25 MHz system clock
  input wire logic nrst, // Async reset, active low
  input wire logic eventPin, // External event input pin
  input wire logic oscOut, // Resistive oscillator output
  input wire logic resistiveOscEnable, // Selects oscillator over pin
  input wire logic [9:0] awaddr, // Write address
  input wire logic [2:0] awprot, // Write protection, unused
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [9:0] araddr, // Read address
  input wire logic [2:0] arprot, // Read protection, unused
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic irqOut // Level interrupt, active high
);
  typedef struct packed {
    logic awHeld;
    logic [9:0] awAddr;
    logic wHeld;
    logic [7:0] wData;
    logic wLane;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
    logic awReady;
    logic wReady;
    logic arReady;
    logic irq;
    logic run;
    logic [2:0] rate;
    logic cks;
    logic ien;
    logic flag;
    logic wme;
    logic pol;
    logic [7:0] lowLatch;
    logic [15:0] cnt;
    logic [1:0] stat;
    logic [1:0] mask;
    tmr_pkg::tmr_wstate_t ws;
  } tmr_core_state_t;

  localparam tmr_core_state_t ST_RST = '{
    ws: tmr_pkg::TMR_WAIT,
    default: '0
  };

  tmr_core_state_t st;
  tmr_core_state_t nx;
  logic preTick;
  logic srcIn;
  logic rise;
  logic fall;
  logic startEdge;
  logic stopEdge;
  logic srcEdge;
  logic cntInc;
  logic ovfEvt;
  logic widthEvt;
  logic wrGo;
  logic loadHigh;
  logic rdGo;
  logic [7:0] wIdx;
  logic [7:0] rIdx;

  ////////////////////////////////////////////////////////////////////////
  // Count clock sources
  tmr_prescaler #(
    .PRE_W(8)
  ) u_pre (
    .clk(clk),
    .nrst(nrst),
    .runEn(st.run),
    .rateSel(st.rate),
    .tickOut(preTick)
  );

  // Oscillator replaces the pin when its enable is set
  assign srcIn = resistiveOscEnable ? oscOut : eventPin;

  tmr_edge_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .sigIn(srcIn),
    .riseOut(rise),
    .fallOut(fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic for counter, measurement and register bus
  always_comb
  begin
    nx = st;
    wIdx = st.awAddr[9:2];
    rIdx = araddr[9:2];
    // Edge roles by polarity
    startEdge = st.pol ? fall : rise;
    stopEdge = st.pol ? rise : fall;
    srcEdge = st.pol ? rise : fall;
    wrGo = st.awHeld && st.wHeld && !st.bValid;
    loadHigh = wrGo && st.wLane && wIdx == tmr_pkg::HIGH_IDX;
    rdGo = arvalid && st.arReady;
    cntInc = 1'b0;
    widthEvt = 1'b0;
    ovfEvt = 1'b0;

    // Width measurement sequencing
    case (st.ws)
      tmr_pkg::TMR_WAIT:
      begin
        if (st.wme && st.run && startEdge)
          nx.ws = tmr_pkg::TMR_MEAS;
      end
      tmr_pkg::TMR_MEAS:
      begin
        if (!st.wme)
          nx.ws = tmr_pkg::TMR_WAIT;
        else if (stopEdge)
        begin
          nx.ws = tmr_pkg::TMR_HOLD;
          widthEvt = 1'b1;
        end
        else
          cntInc = st.run && preTick;
      end
      tmr_pkg::TMR_HOLD:
      begin
        // Count frozen; rearm once software drops the flag
        if (!st.wme || !st.flag)
          nx.ws = tmr_pkg::TMR_WAIT;
      end
      default:
        nx.ws = tmr_pkg::TMR_WAIT;
    endcase

    // Ordinary timer or event counting
    if (!st.wme)
      cntInc = st.run && (st.cks ? srcEdge : preTick);
    // A load beats an increment in the same cycle
    if (cntInc && !loadHigh)
    begin
      nx.cnt = st.cnt + 16'h0001;
      ovfEvt = st.cnt == tmr_pkg::CNT_ALL_ONES;
    end

    // Write channel capture, either order
    if (awvalid && st.awReady)
    begin
      nx.awHeld = 1'b1;
      nx.awAddr = awaddr;
    end
    if (wvalid && st.wReady)
    begin
      nx.wHeld = 1'b1;
      nx.wData = wdata[7:0];
      nx.wLane = wstrb[0];
    end
    if (bready && st.bValid)
      nx.bValid = 1'b0;

    // Read: answer next cycle; high read latches low byte
    if (rready && st.rValid)
      nx.rValid = 1'b0;
    if (rdGo)
    begin
      nx.rValid = 1'b1;
      nx.rResp = tmr_pkg::RESP_OKAY;
      case (rIdx)
        tmr_pkg::MODE_IDX:
          nx.rData = {st.run, st.rate, st.cks, 1'b0, st.ien, st.flag};
        tmr_pkg::LOW_IDX:
          nx.rData = st.lowLatch;
        tmr_pkg::HIGH_IDX:
        begin
          nx.rData = st.cnt[15:8];
          nx.lowLatch = st.cnt[7:0];
        end
        tmr_pkg::EDGE_IDX:
          nx.rData = {6'h00, st.wme, st.pol};
        tmr_pkg::STAT_IDX:
        begin
          nx.rData = {6'h00, st.stat};
          nx.stat = '0;
        end
        tmr_pkg::MASK_IDX:
          nx.rData = {6'h00, st.mask};
        default:
        begin
          nx.rData = 8'h00;
          nx.rResp = tmr_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Write commit once address and data are both held
    if (wrGo)
    begin
      nx.awHeld = 1'b0;
      nx.wHeld = 1'b0;
      nx.bValid = 1'b1;
      nx.bResp = tmr_pkg::RESP_OKAY;
      case (wIdx)
        tmr_pkg::MODE_IDX:
        begin
          if (st.wLane)
          begin
            nx.run = st.wData[tmr_pkg::RUN_BIT];
            nx.rate = st.wData[tmr_pkg::RATE_HI:tmr_pkg::RATE_LO];
            nx.cks = st.wData[tmr_pkg::CKS_BIT];
            nx.ien = st.wData[tmr_pkg::IEN_BIT];
            nx.flag = st.wData[tmr_pkg::FLAG_BIT];
          end
        end
        tmr_pkg::LOW_IDX:
        begin
          // Latch only; the counter is untouched
          if (st.wLane)
            nx.lowLatch = st.wData;
        end
        tmr_pkg::HIGH_IDX:
        begin
          if (st.wLane)
            nx.cnt = {st.wData, st.lowLatch};
        end
        tmr_pkg::EDGE_IDX:
        begin
          if (st.wLane)
          begin
            nx.wme = st.wData[tmr_pkg::WME_BIT];
            nx.pol = st.wData[tmr_pkg::POL_BIT];
          end
        end
        tmr_pkg::STAT_IDX:
          nx.bResp = tmr_pkg::RESP_OKAY;
        tmr_pkg::MASK_IDX:
        begin
          if (st.wLane)
            nx.mask = st.wData[tmr_pkg::ST_W-1:0];
        end
        default:
          nx.bResp = tmr_pkg::RESP_SLVERR;
      endcase
    end

    // Hardware set beats any clear in the same cycle
    if (ovfEvt || widthEvt)
      nx.flag = 1'b1;
    if (ovfEvt)
      nx.stat[tmr_pkg::ST_OVF] = 1'b1;
    if (widthEvt)
      nx.stat[tmr_pkg::ST_WIDTH] = 1'b1;

    // Registered readies and interrupt from the next state
    nx.awReady = !nx.awHeld && !nx.bValid;
    nx.wReady = !nx.wHeld && !nx.bValid;
    nx.arReady = !nx.rValid;
    nx.irq = (nx.flag && nx.ien) || |(nx.stat & nx.mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st <= ST_RST;
    else
      st <= nx;
  end

  // Outputs straight from the state
  assign awready = st.awReady;
  assign wready = st.wReady;
  assign bvalid = st.bValid;
  assign bresp = st.bResp;
  assign arready = st.arReady;
  assign rvalid = st.rValid;
  assign rresp = st.rResp;
  assign rdata = {24'h000000, st.rData};
  assign irqOut = st.irq;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the counter, measurement and register effects
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  ovf_wrap_a: assert property (
    (st.cnt == 16'hffff && cntInc && !loadHigh)
      |=> (st.cnt == 16'h0000 && st.flag))
    else $error("overflow did not wrap or set flag");

  irq_gate_a: assert property (
    ((st.flag && st.ien) |-> irqOut)
      and ((!st.ien && st.stat == 2'h0) |-> !irqOut))
    else $error("interrupt gating wrong");

  run_stop_a: assert property (
    (!st.run && !loadHigh) |=> $stable(st.cnt))
    else $error("counter moved while stopped");

  edge_count_a: assert property (
    (st.run && st.cks && !st.wme && !loadHigh
      && (st.pol ? rise : fall))
      |=> st.cnt == $past(st.cnt) + 16'h0001)
    else $error("selected edge not counted");

  width_stop_a: assert property (
    (st.ws == tmr_pkg::TMR_MEAS && st.wme && stopEdge)
      |=> (st.ws == tmr_pkg::TMR_HOLD && st.flag))
    else $error("width end not held");

  width_hold_a: assert property (
    (st.ws == tmr_pkg::TMR_HOLD && !loadHigh) |=> $stable(st.cnt))
    else $error("count moved during hold");

  width_start_a: assert property (
    (st.ws == tmr_pkg::TMR_WAIT && st.wme && st.run && startEdge)
      |=> st.ws == tmr_pkg::TMR_MEAS)
    else $error("start edge did not begin measure");

  high_read_a: assert property (
    (rdGo && rIdx == tmr_pkg::HIGH_IDX && !(wrGo && st.wLane
      && wIdx == tmr_pkg::LOW_IDX))
      |=> (st.lowLatch == $past(st.cnt[7:0])
        && st.rData == $past(st.cnt[15:8])))
    else $error("high read did not latch low byte");

  high_load_a: assert property (
    loadHigh |=> st.cnt == {$past(st.wData), $past(st.lowLatch)})
    else $error("high write did not load counter");

  flag_clear_a: assert property (
    (wrGo && st.wLane && wIdx == tmr_pkg::MODE_IDX
      && !st.wData[0] && !ovfEvt && !widthEvt) |=> !st.flag)
    else $error("flag not cleared by write of zero");
endmodule : tmr_core

/* logic/tmr_edge_sync.sv */
// Two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/100ps
module tmr_edge_sync (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic sigIn, // Asynchronous event source
  output logic riseOut, // One-cycle pulse per rising edge
  output logic fallOut // One-cycle pulse per falling edge
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } tmr_sync_state_t;

  tmr_sync_state_t st;
  tmr_sync_state_t nx;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second; edges come from later stages
  always_comb
  begin
    nx = st;
    nx.s1 = sigIn;
    nx.s2 = st.s1;
    nx.prev = st.s2;
    riseOut = st.s2 && !st.prev;
    fallOut = !st.s2 && st.prev;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= nx;
  end
endmodule : tmr_edge_sync

/* logic/tmr_prescaler.sv */
// Prescaler giving one-cycle count ticks at clk/2 to clk/256
`timescale 1ns/100ps
module tmr_prescaler #(
  parameter int PRE_W = 8
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic runEn, // Count enable; low clears the divider
  input wire logic [2:0] rateSel, // Code 0 is /256, code 7 is /2
  output logic tickOut // One-cycle tick at the chosen rate
);
  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } tmr_pre_state_t;

  tmr_pre_state_t st;
  tmr_pre_state_t nx;
  logic [PRE_W-1:0] mask;

  ////////////////////////////////////////////////////////////////////////
  // Tick when the low bits selected by the rate are all ones
  always_comb
  begin
    nx = st;
    mask = PRE_W'(tmr_pkg::PRE_ALL_ONES >> rateSel);
    tickOut = runEn && ((st.cnt & mask) == mask);
    // Cleared while stopped so the first interval is full length
    nx.cnt = runEn ? st.cnt + 1'b1 : '0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= nx;
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  div_two_a: assert property (
    (tickOut && rateSel == 3'h7) ##1 (rateSel == 3'h7 && runEn)
      |-> !tickOut ##1 (tickOut || rateSel != 3'h7 || !runEn))
    else $error("divide by two tick spacing wrong");
endmodule : tmr_prescaler

/* shared/tmr_pkg.sv */
// Register map, field layout and state codes of the 16-bit timer
package tmr_pkg;
  // Bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [7:0] MODE_IDX = 8'ha0;
  localparam logic [7:0] LOW_IDX = 8'ha1;
  localparam logic [7:0] HIGH_IDX = 8'ha2;
  localparam logic [7:0] EDGE_IDX = 8'hbf;
  localparam logic [7:0] STAT_IDX = 8'hc0;
  localparam logic [7:0] MASK_IDX = 8'hc1;
  // Mode register fields
  localparam int RUN_BIT = 7;
  localparam int RATE_HI = 6;
  localparam int RATE_LO = 4;
  localparam int CKS_BIT = 3;
  localparam int IEN_BIT = 1;
  localparam int FLAG_BIT = 0;
  // Edge control register fields
  localparam int WME_BIT = 1;
  localparam int POL_BIT = 0;
  // Status and mask fields
  localparam int ST_OVF = 0;
  localparam int ST_WIDTH = 1;
  localparam int ST_W = 2;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [1:0] EDGE_RST = 2'h0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Counter limits
  localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
  localparam logic [7:0] PRE_ALL_ONES = 8'hff;
  // Pulse-width measurement states
  typedef enum logic [2:0] {
    TMR_WAIT = 3'h1,
    TMR_MEAS = 3'h2,
    TMR_HOLD = 3'h4
  } tmr_wstate_t;
endpackage : tmr_pkg

/* verif/tmr_core_tb_top.sv */
// Self-checking bench for the timer over its register bus
`timescale 1ns/100ps
module tmr_core_tb_top;
  localparam logic [9:0] A_MODE = {tmr_pkg::MODE_IDX, 2'b00};
  localparam logic [9:0] A_LOW = {tmr_pkg::LOW_IDX, 2'b00};
  localparam logic [9:0] A_HIGH = {tmr_pkg::HIGH_IDX, 2'b00};
  localparam logic [9:0] A_EDGE = {tmr_pkg::EDGE_IDX, 2'b00};
  localparam logic [9:0] A_STAT = {tmr_pkg::STAT_IDX, 2'b00};
  localparam logic [9:0] A_MASK = {tmr_pkg::MASK_IDX, 2'b00};
  logic clk, nrst, eventPin, oscOut, resistiveOscEnable, srcGo;
  logic [9:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, pinLvl, oscLvl;
  logic awready, wready, bvalid, arready, rvalid, irqOut;
  logic [31:0] wdata, rdata, got;
  logic [1:0] bresp, rresp, rr;
  logic [3:0] pinN;
  logic [7:0] pinH;
  int failCount, checkCount, cyc, exp8;
  //////////////////////////////////////////////////////////////////////
  // Design and the two event sources
  tmr_core dut (.clk(clk), .nrst(nrst), .eventPin(eventPin),
    .oscOut(oscOut), .resistiveOscEnable(resistiveOscEnable),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irqOut(irqOut));
  tmr_event_src pinSrc (.clk(clk), .startPulse(srcGo),
    .toggleCount(pinN), .halfPeriod(pinH), .sigOut(eventPin));
  tmr_event_src oscSrc (.clk(clk), .startPulse(srcGo),
    .toggleCount(4'h3), .halfPeriod(8'h04), .sigOut(oscOut));
  //////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial
    clk = 1'b0;
  always #20 clk = ~clk;
  // Comparisons and verdict
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checkCount++;
    if (g !== e)
    begin
      failCount++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic inRange(input logic [31:0] g, input int lo, input int hi);
    checkCount++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      failCount++;
      $display("mismatch at %0t got %h expected %h", $time, g, lo);
    end
  endtask : inRange
  task automatic reportAndStop;
    if (failCount == 0 && checkCount > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : reportAndStop
  //////////////////////////////////////////////////////////////////////
  // Bus master; readies and answers taken at the rising edge itself
  task automatic axiWrite(input logic [9:0] a, input logic [7:0] d);
    int n;
    logic b;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    r = 2'h0;
    n = 0;
    while (!b && n < 100)
    begin
      // Outputs read here still hold what this edge sampled
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      b = bvalid;
      r = bresp;
      n++;
    end
    bready <= 1'b0;
    if (!b)
      failCount++;
    check({30'h0, r}, {30'h0, tmr_pkg::RESP_OKAY});
  endtask : axiWrite
  task automatic axiRead(input logic [9:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    logic v;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    v = 1'b0;
    n = 0;
    while (!v && n < 100)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      v = rvalid;
      d = rdata;
      r = rresp;
      n++;
    end
    rready <= 1'b0;
    if (!v)
      failCount++;
  endtask : axiRead
  task automatic readCheck(input logic [9:0] a, input logic [7:0] e);
    axiRead(a, got, rr);
    check(got, {24'h0, e});
    check({30'h0, rr}, {30'h0, tmr_pkg::RESP_OKAY});
  endtask : readCheck
  task automatic waitIrq;
    cyc = 0;
    while (irqOut !== 1'b1 && cyc < 1000)
    begin
      @(negedge clk);
      cyc++;
    end
  endtask : waitIrq
  task automatic startSrc;
    @(posedge clk);
    srcGo <= 1'b1;
    @(posedge clk);
    srcGo <= 1'b0;
  endtask : startSrc
  // Edges of one sense in n changes from a start level
  function automatic int edgesOf(input logic lvl, input int n,
    input logic rising);
    return (lvl ^ rising) ? (n + 1) / 2 : n / 2;
  endfunction : edgesOf
  //////////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the few thousand cycles needed
  initial
  begin
    repeat (20000) @(posedge clk);
    failCount++;
    reportAndStop();
  end
  // Main sequence
  initial
  begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, srcGo} = 7'h00;
    {awaddr, araddr, wdata, pinN, pinH} = '0;
    {resistiveOscEnable, pinLvl, oscLvl} = 3'h0;
    failCount = 0;
    checkCount = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    readCheck(A_MODE, tmr_pkg::MODE_RST);
    readCheck(A_EDGE, 8'h00);
    readCheck(A_STAT, 8'h00);
    axiRead(10'h3fc, got, rr);
    check({30'h0, rr}, {30'h0, tmr_pkg::RESP_SLVERR});
    // Low write alone leaves the count; high read refreshes the latch
    axiWrite(A_LOW, 8'h34);
    readCheck(A_HIGH, 8'h00);
    readCheck(A_LOW, 8'h00);
    axiWrite(A_LOW, 8'h34);
    axiWrite(A_HIGH, 8'h12);
    readCheck(A_HIGH, 8'h12);
    readCheck(A_LOW, 8'h34);
    // Every rate code: two ticks from preload to wrap
    for (int r = 0; r < 8; r++)
    begin
      axiWrite(A_MODE, 8'h00);
      axiWrite(A_LOW, 8'hfe);
      axiWrite(A_HIGH, 8'hff);
      axiWrite(A_MODE, 8'h82 | 8'(r << 4));
      waitIrq();
      inRange(cyc, 2 * (256 >> r) - 3, 2 * (256 >> r) + 4);
      readCheck(A_MODE, 8'h83 | 8'(r << 4));
      readCheck(A_STAT, 8'h01);
    end
    // Enable bit and mask gate the interrupt
    axiWrite(A_MODE, 8'h00);
    axiWrite(A_LOW, 8'hfe);
    axiWrite(A_HIGH, 8'hff);
    axiWrite(A_MODE, 8'hf0);
    repeat (20) @(negedge clk);
    check({31'h0, irqOut}, 32'h0);
    readCheck(A_MODE, 8'hf1);
    axiWrite(A_MASK, 8'h01);
    @(negedge clk);
    check({31'h0, irqOut}, 32'h1);
    readCheck(A_STAT, 8'h01);
    @(negedge clk);
    check({31'h0, irqOut}, 32'h0);
    axiWrite(A_MASK, 8'h00);
    axiWrite(A_MODE, 8'h00);
    readCheck(A_MODE, 8'h00);
    // External source, both polarities, pin then oscillator
    for (int k = 0; k < 4; k++)
    begin
      resistiveOscEnable <= k[1];
      axiWrite(A_LOW, 8'h00);
      axiWrite(A_HIGH, 8'h00);
      axiWrite(A_EDGE, {7'h0, k[0]});
      axiWrite(A_MODE, 8'h88);
      pinN <= 4'h5;
      pinH <= 8'h03;
      startSrc();
      repeat (40) @(posedge clk);
      axiWrite(A_MODE, 8'h00);
      exp8 = k[1] ? edgesOf(oscLvl, 3, k[0]) : edgesOf(pinLvl, 5, k[0]);
      readCheck(A_HIGH, 8'h00);
      readCheck(A_LOW, 8'(exp8));
      pinLvl = ~pinLvl;
      oscLvl = ~oscLvl;
    end
    // Width of a 40-cycle pulse at clock/2; second pass rearms
    resistiveOscEnable <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      axiWrite(A_MODE, 8'h00);
      axiWrite(A_LOW, 8'h00);
      axiWrite(A_HIGH, 8'h00);
      axiWrite(A_EDGE, 8'h02 | 8'(k));
      axiWrite(A_MODE, 8'hf0);
      pinN <= 4'h4;
      pinH <= 8'd40;
      startSrc();
      repeat (180) @(posedge clk);
      readCheck(A_MODE, 8'hf1);
      readCheck(A_HIGH, 8'h00);
      axiRead(A_LOW, got, rr);
      inRange(got, 19, 21);
      readCheck(A_STAT, 8'h02);
    end
    reportAndStop();
  end
endmodule : tmr_core_tb_top

/* verif/tmr_event_src.sv */
// Event source model: a train of level changes on one line
`timescale 1ns/100ps
module tmr_event_src (
  input wire logic clk, // Bench clock
  input wire logic startPulse, // One-cycle start of a train
  input wire logic [3:0] toggleCount, // Level changes per train
  input wire logic [7:0] halfPeriod, // Cycles between changes
  output logic sigOut // Event line, starts low
);
  logic [3:0] left_reg;
  logic [7:0] cnt_reg;
  //////////////////////////////////////////////////////////////////////
  // Known start level, so the bench can predict every edge
  initial
  begin
    sigOut = 1'b0;
    left_reg = 4'h0;
    cnt_reg = 8'h00;
  end
  // Changes only just after an edge, steady in between
  always @(posedge clk)
  begin
    if (startPulse)
    begin
      left_reg <= toggleCount;
      cnt_reg <= halfPeriod;
    end
    else if (left_reg != 4'h0)
    begin
      if (cnt_reg == 8'h01)
      begin
        sigOut <= ~sigOut;
        left_reg <= left_reg - 4'h1;
        cnt_reg <= halfPeriod;
      end
      else
        cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule : tmr_event_src
